// ===== verilog/asep_defines.vh
// Constants for the static RAM host controller.
// Assumes a 25 MHz core clock (40 ns period).
`ifndef ASEP_DEFINES_VH
`define ASEP_DEFINES_VH
`define ASEP_CLK_PERIOD_NS   40
// Read cycle and access time, ns
`define ASEP_T_RC_NS         45
// Write pulse least time, ns (output turn-off 18 + data setup 25)
`define ASEP_T_HZWE_NS       18
`define ASEP_T_SD_NS         25
`define ASEP_T_PWE_NS        35
// Output turn-off after strobe release, ns
`define ASEP_T_HZOE_NS       18
// Cycle counts, least times rounded up
`define ASEP_CYC(ns)  (((ns)+`ASEP_CLK_PERIOD_NS-1)/`ASEP_CLK_PERIOD_NS)
`define ASEP_WR_SUM_NS (`ASEP_T_HZWE_NS+`ASEP_T_SD_NS)
`define ASEP_WR_NS    (`ASEP_WR_SUM_NS > `ASEP_T_PWE_NS ? \
                       `ASEP_WR_SUM_NS : `ASEP_T_PWE_NS)
`define ASEP_RD_CYC   `ASEP_CYC(`ASEP_T_RC_NS)
`define ASEP_WR_CYC   `ASEP_CYC(`ASEP_WR_NS)
`define ASEP_TA_CYC   `ASEP_CYC(`ASEP_T_HZOE_NS)
`endif

// ===== verilog/asep_host.v
// Host controller driving an asynchronous ECC static RAM.
// Assumes a single request at a time; data pins are resolved by the bench.
//
// Operation
// [R1] Device selected only when select_n low and select_p high.
// [R2] Deselected device floats data and idles regardless of other pins.
// [R3] Sixteen-bit mode with both lane enables high floats data.
// [R4] Write strobe held high through every read cycle.
// [R5] Sixteen-bit read with both lanes drives the whole word.
// [R6] Single-lane read drives only that lane; lower is bits 0-7.
// [R7] Sixteen-bit write with both lanes stores the whole word.
// [R8] Single-lane write updates only the enabled byte.
// [R9] Eight-bit read returns a byte on bits 0-7, lanes ignored.
// [R10] Eight-bit write stores bits 0-7, lanes ignored.
// [R11] Write starts when strobe, selects and a lane are all active.
// [R12] Write ends when first qualifying signal goes inactive.
// [R13] Host holds write data stable around the terminating edge.
// [R14] Device floats data when deselected, output strobe high, lane off.
// [R15] Write pulse with output strobe low lasts turn-off plus setup.
// [R16] Host never drives the data bus while the device drives it.
// [R17] Address valid before or with the combined select going active.
// [R18] Deselect with strobe release keeps outputs floating.
// [R19] Width select is a static strap: high sixteen-bit, low eight-bit; the host reloads it from wide_mode_i in every idle cycle.
// [R20] Error flag low on clean read, high on corrected error.
// [R21] Memory is 512K words by 19-bit address, plus byte address.
// [R22] Reads return the corrected value of the location.
`timescale 1ns/100ps
`include "asep_defines.vh"
module asep_host
#(
  parameter ADDR_W = 19,
  parameter DATA_W = 16,
  parameter RD_CYC = `ASEP_RD_CYC,
  parameter WR_CYC = `ASEP_WR_CYC,
  parameter TA_CYC = `ASEP_TA_CYC
)
(
  input  wire              core_clk_i,
  input  wire              resetn_i,
  // User request side
  input  wire              req_valid_i,
  input  wire              req_write_i,
  input  wire [ADDR_W:0]   req_addr_i,
  input  wire [DATA_W-1:0] req_wdata_i,
  input  wire [1:0]        req_lane_i,
  input  wire              wide_mode_i,
  output reg               req_ready_o,
  output reg               rsp_valid_o,
  output reg  [DATA_W-1:0] rsp_rdata_o,
  output reg               rsp_err_o,
  // Memory pins
  output reg  [ADDR_W-1:0] mem_addr_o,
  output reg               mem_byte_addr_o,
  output reg               select_n_o,
  output reg               select_p_o,
  output reg               write_n_o,
  output reg               out_en_n_o,
  output reg               upper_lane_enable_n_o,
  output reg               lower_lane_enable_n_o,
  output reg               width_sel_o,
  input  wire [DATA_W-1:0] mem_data_i,
  output reg  [DATA_W-1:0] mem_data_o,
  output reg  [DATA_W-1:0] mem_data_oe_o,
  input  wire              mem_err_i
);

////////////////////////////////////////////////////////////////////////////
reg [2:0] state;
reg [7:0] cnt;
reg       is_write;
reg [1:0] lanes;

////////////////////////////////////////////////////////////////////////////
// State codes
localparam [2:0] ST_IDLE  = 3'h0;
localparam [2:0] ST_SETUP = 3'h1;
localparam [2:0] ST_READ  = 3'h2;
localparam [2:0] ST_WRITE = 3'h3;
localparam [2:0] ST_HOLD  = 3'h4;
localparam [2:0] ST_TURN  = 3'h5;

// Per-bit data enables from the two lane flags
function [DATA_W-1:0] lane_bits;
  input [1:0] ln;
  begin
    lane_bits = {{8{ln[1]}}, {8{ln[0]}}};
  end
endfunction

// Effective lane mask: eight-bit mode uses the low lane only
function [1:0] lane_mask;
  input       wide;
  input [1:0] ln;
  begin
    lane_mask = wide ? ln : 2'h1; // [R9] [R10]
  end
endfunction

////////////////////////////////////////////////////////////////////////////
always @(posedge core_clk_i or negedge resetn_i)
begin
  if (!resetn_i)
  begin
    state                 <= ST_IDLE;
    cnt                   <= 8'h00;
    is_write              <= 1'b0;
    lanes                 <= 2'h0;
    req_ready_o           <= 1'b0;
    rsp_valid_o           <= 1'b0;
    rsp_rdata_o           <= {DATA_W{1'b0}};
    rsp_err_o             <= 1'b0;
    mem_addr_o            <= {ADDR_W{1'b0}};
    mem_byte_addr_o       <= 1'b0;
    select_n_o            <= 1'b1;
    select_p_o            <= 1'b0;
    write_n_o             <= 1'b1;
    out_en_n_o            <= 1'b1;
    upper_lane_enable_n_o <= 1'b1;
    lower_lane_enable_n_o <= 1'b1;
    width_sel_o           <= 1'b1;
    mem_data_o            <= {DATA_W{1'b0}};
    mem_data_oe_o         <= {DATA_W{1'b0}};
  end
  else
  begin
    rsp_valid_o <= 1'b0;
    case (state)
      ST_IDLE:
      begin
        width_sel_o <= wide_mode_i; // [R19]
        req_ready_o <= 1'b1;
        if (req_valid_i && req_ready_o)
        begin
          req_ready_o     <= 1'b0;
          is_write        <= req_write_i;
          // Mask follows the width this access will run with
          lanes           <= lane_mask(wide_mode_i, req_lane_i);
          // Address first, select one cycle later
          mem_addr_o      <= req_addr_i[ADDR_W:1]; // [R17] [R21]
          mem_byte_addr_o <= req_addr_i[0];
          mem_data_o      <= req_wdata_i;
          state           <= ST_SETUP;
        end
      end

      ST_SETUP:
      begin
        select_n_o            <= 1'b0; // [R1]
        select_p_o            <= 1'b1;
        upper_lane_enable_n_o <= ~lanes[1]; // [R6] [R8]
        lower_lane_enable_n_o <= ~lanes[0];
        cnt                   <= 8'h00;
        if (is_write)
        begin
          write_n_o     <= 1'b0; // [R11] [R15]
          out_en_n_o    <= 1'b1; // [R16]
          mem_data_oe_o <= lane_bits(lanes); // [R7] [R8]
          state         <= ST_WRITE;
        end
        else
        begin
          write_n_o  <= 1'b1; // [R4]
          out_en_n_o <= 1'b0; // [R5] [R9]
          state      <= ST_READ;
        end
      end

      ST_READ:
      begin
        cnt <= cnt + 8'h01;
        if (cnt == RD_CYC[7:0])
        begin
          // Corrected data and flag captured at access end
          rsp_rdata_o <= mem_data_i & lane_bits(lanes); // [R22]
          rsp_err_o   <= mem_err_i; // [R20]
          rsp_valid_o <= 1'b1;
          out_en_n_o  <= 1'b1; // [R14]
          select_n_o  <= 1'b1; // [R2]
          select_p_o  <= 1'b0;
          upper_lane_enable_n_o <= 1'b1; // [R3]
          lower_lane_enable_n_o <= 1'b1;
          cnt         <= 8'h00;
          state       <= ST_TURN;
        end
      end

      ST_WRITE:
      begin
        cnt <= cnt + 8'h01;
        if (cnt == WR_CYC[7:0] - 8'h01)
        begin
          // Strobe ends the write; data held one more cycle
          write_n_o <= 1'b1; // [R12] [R13]
          state     <= ST_HOLD;
        end
      end

      ST_HOLD:
      begin
        select_n_o            <= 1'b1; // [R18]
        select_p_o            <= 1'b0;
        upper_lane_enable_n_o <= 1'b1;
        lower_lane_enable_n_o <= 1'b1;
        mem_data_oe_o         <= {DATA_W{1'b0}}; // [R13]
        rsp_valid_o           <= 1'b1;
        rsp_err_o             <= 1'b0;
        cnt                   <= 8'h00;
        state                 <= ST_TURN;
      end

      ST_TURN:
      begin
        // Bus turnaround so device outputs reach high impedance
        cnt <= cnt + 8'h01;
        if (cnt >= TA_CYC[7:0] - 8'h01)
          state <= ST_IDLE; // [R16]
      end

      default:
        state <= ST_IDLE;
    endcase
  end
end

endmodule // asep_host

// ===== testbench/asep_chk.sv
// Checker on the host controller pins.
// Assumes default cycle counts (RD_CYC=2, WR_CYC=2).
`timescale 1ns/100ps
module asep_chk
(
  input wire        core_clk_i,
  input wire        resetn_i,
  input wire        req_valid_i,
  input wire        req_ready_o,
  input wire        rsp_valid_o,
  input wire        select_n_o,
  input wire        select_p_o,
  input wire        write_n_o,
  input wire        out_en_n_o,
  input wire        width_sel_o,
  input wire        upper_lane_enable_n_o,
  input wire        lower_lane_enable_n_o,
  input wire [18:0] mem_addr_o,
  input wire [15:0] mem_data_o,
  input wire [15:0] mem_data_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sel_pair_a: assert property (select_n_o == !select_p_o)
    else $error("selects split");
  rd_wr_high_a: assert property (!out_en_n_o |-> write_n_o)
    else $error("strobe low in read");
  wr_qual_a: assert property (!write_n_o |-> !select_n_o &&
    !(upper_lane_enable_n_o && lower_lane_enable_n_o)) else $error("bad wr");
  wr_pulse_a: assert property ($fell(write_n_o) |-> !write_n_o [*2])
    else $error("short pulse");
  wr_hold_a: assert property ($rose(write_n_o) |->
    $stable(mem_data_o) && $stable(mem_data_oe_o)) else $error("no hold");
  no_fight_a: assert property (|mem_data_oe_o |-> out_en_n_o)
    else $error("bus fight");
  addr_first_a: assert property (
    $fell(select_n_o) |-> $stable(mem_addr_o)) else $error("late address");
  strap_hold_a: assert property (!select_n_o |-> $stable(width_sel_o))
    else $error("strap moved");
  lane_drive_a: assert property (!write_n_o |-> mem_data_oe_o ==
    {{8{!upper_lane_enable_n_o}}, {8{!lower_lane_enable_n_o}}})
    else $error("lane drive");
  rsp_time_a: assert property (
    req_valid_i && req_ready_o |-> ##5 rsp_valid_o) else $error("late answer");
endmodule // asep_chk
bind asep_host asep_chk chk (.*);

// ===== testbench/asep_ram.sv
// Behavioural RAM device on the pin side, 256 words kept.
// Assumes host data and enables come straight from the controller.
`timescale 1ns/100ps
module asep_ram
(
  input  wire [18:0] a_i,
  input  wire        b_i,
  input  wire        sel_n_i,
  input  wire        sel_p_i,
  input  wire        we_n_i,
  input  wire        oe_n_i,
  input  wire        ub_n_i,
  input  wire        lb_n_i,
  input  wire        wide_i,
  input  wire        inj_i,
  input  wire [15:0] hd_i,
  input  wire [15:0] hoe_i,
  output wire [15:0] bus_o,
  output wire        err_o
);
  reg  [15:0] m [0:255];
  wire        sel = !sel_n_i && sel_p_i;
  wire        lo = !lb_n_i || !wide_i;
  wire        hi = !ub_n_i && wide_i;
  wire        rd = sel && we_n_i && !oe_n_i;
  wire [15:0] w = m[a_i[7:0]];
  wire [15:0] dev = (wide_i || !b_i) ? w : {8'h00, w[15:8]};
  wire [15:0] den = rd ? {{8{hi}}, {8{lo}}} : 16'h0000;
  wire        wr = sel && !we_n_i && (lo || hi);
  // Undriven bits show the inverse of the value the device would drive
  assign bus_o = (hoe_i & hd_i) | (den & dev) | (~hoe_i & ~den & ~dev);
  assign err_o = rd ? inj_i : 1'b1;
  always @(negedge wr)
    if (wide_i)
      m[a_i[7:0]] <= {hi ? hd_i[15:8] : w[15:8], lo ? hd_i[7:0] : w[7:0]};
    else if (b_i)
      m[a_i[7:0]][15:8] <= hd_i[7:0];
    else
      m[a_i[7:0]][7:0] <= hd_i[7:0];
endmodule // asep_ram

// ===== testbench/tb_top.sv
// Bench: host controller against the RAM model.
// Assumes the model answers at once; no random stimulus.
`timescale 1ns/100ps
module tb_top;
  reg core_clk_i = 0, resetn_i = 0, req_valid_i = 0, req_write_i = 0;
  reg wide_mode_i = 1, inj = 0;
  reg [19:0] req_addr_i = 0;
  reg [15:0] req_wdata_i = 0;
  reg [1:0] req_lane_i = 0;
  wire req_ready_o, rsp_valid_o, rsp_err_o, select_n_o, select_p_o;
  wire write_n_o, out_en_n_o, upper_lane_enable_n_o, lower_lane_enable_n_o;
  wire width_sel_o, mem_byte_addr_o, mem_err_i;
  wire [18:0] mem_addr_o;
  wire [15:0] rsp_rdata_o, mem_data_i, mem_data_o, mem_data_oe_o;
  integer mismatches = 0, tests_run = 0;
  always #20 core_clk_i = ~core_clk_i;
  asep_host DUT (.*);
  asep_ram M (.a_i(mem_addr_o), .b_i(mem_byte_addr_o), .sel_n_i(select_n_o),
    .sel_p_i(select_p_o), .we_n_i(write_n_o), .oe_n_i(out_en_n_o),
    .ub_n_i(upper_lane_enable_n_o), .lb_n_i(lower_lane_enable_n_o),
    .wide_i(width_sel_o), .hd_i(mem_data_o), .hoe_i(mem_data_oe_o),
    .inj_i(inj), .bus_o(mem_data_i), .err_o(mem_err_i));
  task op(input w, input [19:0] a, input [15:0] d, input [1:0] l, input e);
    integer i;
    begin
      for (i = 0; i < 20 && req_ready_o !== 1'b1; i = i + 1)
        @(negedge core_clk_i);
      {req_write_i, req_addr_i, req_wdata_i, req_lane_i} = {w, a, d, l};
      req_valid_i = 1;
      @(negedge core_clk_i);
      req_valid_i = 0;
      for (i = 0; i < 9 && rsp_valid_o !== 1'b1; i = i + 1)
        @(negedge core_clk_i);
      tests_run = tests_run + 1;
      if ({rsp_valid_o, w ? d : rsp_rdata_o, rsp_err_o} !==
          {1'b1, d, e})
      begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t got %h want %h", $time,
          {rsp_valid_o, w ? d : rsp_rdata_o, rsp_err_o}, {1'b1, d, e});
      end
    end
  endtask
  task t_word;
    begin
      op(1, 20'h00024, 16'hbeef, 2'h3, 0);
      op(0, 20'h00024, 16'hbeef, 2'h3, 0);
    end
  endtask
  task t_lane;
    begin
      op(1, 20'h00024, 16'h5a00, 2'h2, 0);
      op(0, 20'h00024, 16'h5aef, 2'h3, 0);
      op(0, 20'h00024, 16'h00ef, 2'h1, 0);
      op(0, 20'h00024, 16'h5a00, 2'h2, 0);
    end
  endtask
  task t_byte;
    begin
      wide_mode_i = 0;
      repeat (2) @(negedge core_clk_i);
      op(1, 20'h00041, 16'h0077, 2'h3, 0);
      op(1, 20'h00040, 16'h0011, 2'h3, 0);
      op(0, 20'h00041, 16'h0077, 2'h3, 0);
      wide_mode_i = 1;
      repeat (2) @(negedge core_clk_i);
      op(0, 20'h00040, 16'h7711, 2'h3, 0);
    end
  endtask
  task t_err;
    begin
      inj = 1;
      op(0, 20'h00024, 16'h5aef, 2'h3, 1);
      op(1, 20'h00024, 16'h1234, 2'h3, 0);
      inj = 0;
    end
  endtask
  task final_report;
    begin
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    final_report;
  end
  initial
  begin
    repeat (16) @(negedge core_clk_i);
    resetn_i = 1;
    t_word;
    t_lane;
    t_byte;
    t_err;
    final_report;
  end
endmodule // tb_top
